// >>> common/teach_pkg.sv
package teach_pkg;
   // ---------------------------------------------------------------
   // clock and time base
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int MS_PER_S = 1000;
   localparam int HOLD_MIN_S = 2;
   localparam int ANALOG_MIN_S = 7;
   localparam int ANALOG_MAX_S = 12;
   localparam logic [13:0] HOLD_MIN_MS = 14'(HOLD_MIN_S * MS_PER_S);
   localparam logic [13:0] ANALOG_MIN_MS = 14'(ANALOG_MIN_S * MS_PER_S);
   localparam logic [13:0] ANALOG_MAX_MS = 14'(ANALOG_MAX_S * MS_PER_S);
   localparam logic [13:0] HOLD_SAT_MS = 14'(ANALOG_MAX_S * MS_PER_S + 1);
   localparam int FLASH_TEACH_HZ = 3;
   localparam int FLASH_ERR_HZ = 8;
   localparam logic [9:0] TEACH_HALF_MS = 10'(MS_PER_S / (2 * FLASH_TEACH_HZ));
   localparam logic [9:0] ERR_HALF_MS = 10'(MS_PER_S / (2 * FLASH_ERR_HZ));
   // ---------------------------------------------------------------
   // distances in mm
   // ---------------------------------------------------------------
   localparam logic [15:0] MIN_SPAN_MM = 16'd500;
   localparam logic [15:0] OP_MIN_MM = 16'd600;
   localparam logic [15:0] OP_MAX_MM = 16'd6000;
   localparam logic [15:0] LEVEL_NEAR = 16'hfffe;
   localparam logic [15:0] LEVEL_FAR = 16'hffff;
   localparam logic [15:0] POINT_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // shared line timing
   // ---------------------------------------------------------------
   localparam int MAX_NODES = 10;
   localparam logic [7:0] SLOT_MS = 8'd25;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_POINTS = 8'h08;
   localparam logic [7:0] ADDR_SWITCH = 8'h0c;
   localparam logic [7:0] ADDR_DIST = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MASTER_BIT = 3;
   localparam int CTRL_NODE_LSB = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_RANGE = 2;
   localparam int IRQ_SWITCH = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] AN_IN = 2'h0;
   localparam logic [1:0] AN_NEAR = 2'h1;
   localparam logic [1:0] AN_FAR = 2'h2;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {MODE_STANDARD, MODE_MULTIPLEX, MODE_SYNC, MODE_ACTIVATION, MODE_THROUGHBEAM} mode_t;
   typedef enum logic [1:0] {T_IDLE, T_HOLD, T_WAIT} teach_state_t;
endpackage

// >>> common/teach_evt_if.sv
`timescale 1ns/1ps
// events from the teach line front end to the sequencer
interface teach_evt_if;
   logic msTick;
   logic briefPress;
   logic onePoint;
   logic invertHold;
   logic analogArm;
   logic analogRelease;
   logic longAbort;
   modport src (output msTick, briefPress, onePoint, invertHold, analogArm, analogRelease, longAbort);
   modport dst (input msTick, briefPress, onePoint, invertHold, analogArm, analogRelease, longAbort);
endinterface

// >>> src/teach_input.sv
`timescale 1ns/1ps
module teach_input #(
   parameter int TICK_CYCLES = teach_pkg::CLK_HZ / teach_pkg::MS_PER_S
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic teachGnd,
   input wire logic teachSupply,
   teach_evt_if.src evt
);
   // ---------------------------------------------------------------
   // millisecond tick
   // ---------------------------------------------------------------
   logic [31:0] tickCnt;
   logic msTick;
   wire tickWrap = tickCnt == 32'(TICK_CYCLES - 1);

   // divider sets the time base for every hold and flash figure
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tickCnt <= 32'h0;
         msTick <= 1'b0;
      end else begin
         tickCnt <= tickWrap ? 32'h0 : tickCnt + 32'h1;
         msTick <= tickWrap;
      end
   end

   // ---------------------------------------------------------------
   // per level: synchroniser and hold timer
   // ---------------------------------------------------------------
   wire [1:0] pinRaw = {teachSupply, teachGnd};
   logic [1:0] levelNow;
   logic [1:0] released;
   logic [13:0] heldMs [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gLevel
         logic s1;
         logic s2;
         logic last;
         logic [13:0] ms;
         // pins are asynchronous; s1 is read by s2 only
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               last <= 1'b0;
               ms <= 14'h0;
            end else begin
               s1 <= pinRaw[g];
               s2 <= s1;
               last <= s2;
               if (!s2) begin
                  ms <= 14'h0;
               end else if (msTick && ms != teach_pkg::HOLD_SAT_MS) begin
                  ms <= ms + 14'h1; // saturates just past the longest hold
               end
            end
         end
         assign levelNow[g] = s2;
         assign released[g] = last & ~s2;
         assign heldMs[g] = ms;
      end
   endgenerate

   // ---------------------------------------------------------------
   // classification of holds
   // ---------------------------------------------------------------
   wire [13:0] gndMs = heldMs[0];
   wire [13:0] supMs = heldMs[1];
   wire gndOnePt = gndMs >= teach_pkg::HOLD_MIN_MS && gndMs < teach_pkg::ANALOG_MIN_MS;
   wire gndAnalog = gndMs >= teach_pkg::ANALOG_MIN_MS && gndMs <= teach_pkg::ANALOG_MAX_MS;
   wire supInvert = supMs >= teach_pkg::HOLD_MIN_MS && supMs < teach_pkg::ANALOG_MIN_MS;
   wire armNow = levelNow[0] && msTick && gndMs == teach_pkg::ANALOG_MIN_MS - 14'h1;

   // one-cycle event pulses, decided on release except the arm
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         evt.briefPress <= 1'b0;
         evt.onePoint <= 1'b0;
         evt.invertHold <= 1'b0;
         evt.analogArm <= 1'b0;
         evt.analogRelease <= 1'b0;
         evt.longAbort <= 1'b0;
      end else begin
         evt.briefPress <= released[0] && gndMs < teach_pkg::HOLD_MIN_MS;
         evt.onePoint <= released[0] && gndOnePt;
         evt.invertHold <= released[1] && supInvert;
         evt.analogArm <= armNow;
         evt.analogRelease <= released[0] && gndAnalog;
         evt.longAbort <= released[0] && gndMs > teach_pkg::ANALOG_MAX_MS;
      end
   end

   assign evt.msTick = msTick;
endmodule

// >>> src/analog_teach_sequencer.sv
`timescale 1ns/1ps
module analog_teach_sequencer #(
   parameter int TICK_CYCLES = teach_pkg::CLK_HZ / teach_pkg::MS_PER_S,
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic teachGnd,
   input wire logic teachSupply,
   input wire logic trigger,
   input wire logic syncLineIn,
   output logic syncLineOut,
   output logic syncLineOe,
   input wire logic [15:0] distance,
   input wire logic distValid,
   output logic measureStart,
   output logic [15:0] analogOutput,
   output logic switchingOutput,
   output logic ledYellow,
   output logic ledGreen,
   output logic irq
);
   // ---------------------------------------------------------------
   // teach line front end
   // ---------------------------------------------------------------
   teach_evt_if evt ();

   teach_input #(.TICK_CYCLES(TICK_CYCLES)) frontEnd (
      .clock(clock),
      .sys_rst(sys_rst),
      .teachGnd(teachGnd),
      .teachSupply(teachSupply),
      .evt(evt)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   teach_pkg::teach_state_t tState;
   logic [15:0] curDist;
   logic [15:0] firstPt;
   logic [15:0] nearPt;
   logic [15:0] farPt;
   logic [15:0] switchPoint;
   logic falling;
   logic teachErr;
   logic switchInvert;
   logic [1:0] anState;
   logic [31:0] ctrl;
   logic [3:0] irqStat;
   logic [3:0] irqMask;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   // ---------------------------------------------------------------
   // register bus decode
   // ---------------------------------------------------------------
   wire wrFire = !awready && !wready && !bvalid;
   wire isCtrl = awAddr == ADDR_W'(teach_pkg::ADDR_CTRL);
   wire isIrqStat = awAddr == ADDR_W'(teach_pkg::ADDR_IRQ_STAT);
   wire isIrqMask = awAddr == ADDR_W'(teach_pkg::ADDR_IRQ_MASK);
   wire isRoW = awAddr == ADDR_W'(teach_pkg::ADDR_STATUS) || awAddr == ADDR_W'(teach_pkg::ADDR_POINTS)
      || awAddr == ADDR_W'(teach_pkg::ADDR_SWITCH) || awAddr == ADDR_W'(teach_pkg::ADDR_DIST);
   wire wrMapped = isCtrl || isIrqStat || isIrqMask || isRoW;
   wire [31:0] byteMask;
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : gLane
         assign byteMask[8*b +: 8] = {8{wStrb[b]}};
      end
   endgenerate
   wire [31:0] ctrlMerged = (ctrl & ~byteMask) | (wData & byteMask);
   wire [3:0] maskMerged = (irqMask & ~byteMask[3:0]) | (wData[3:0] & byteMask[3:0]);
   wire [3:0] irqClear = (wrFire && isIrqStat) ? (wData[3:0] & byteMask[3:0]) : 4'h0;

   // read mux; status packs state, error, direction, polarity, output, range
   wire [31:0] statusWord = {24'h0, anState, switchingOutput, switchInvert, falling, teachErr, tState};
   wire rdCtrl = araddr == ADDR_W'(teach_pkg::ADDR_CTRL);
   wire rdStatus = araddr == ADDR_W'(teach_pkg::ADDR_STATUS);
   wire rdPoints = araddr == ADDR_W'(teach_pkg::ADDR_POINTS);
   wire rdSwitch = araddr == ADDR_W'(teach_pkg::ADDR_SWITCH);
   wire rdDist = araddr == ADDR_W'(teach_pkg::ADDR_DIST);
   wire rdIrqStat = araddr == ADDR_W'(teach_pkg::ADDR_IRQ_STAT);
   wire rdIrqMask = araddr == ADDR_W'(teach_pkg::ADDR_IRQ_MASK);
   wire rdMapped = rdCtrl || rdStatus || rdPoints || rdSwitch || rdDist || rdIrqStat || rdIrqMask;
   wire [31:0] rdMux = rdCtrl ? ctrl : rdStatus ? statusWord : rdPoints ? {farPt, nearPt}
      : rdSwitch ? {16'h0, switchPoint} : rdDist ? {16'h0, curDist}
      : rdIrqStat ? {28'h0, irqStat} : rdIrqMask ? {28'h0, irqMask} : 32'h0;

   // write side: address and data taken in either order, answer after both
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= teach_pkg::RESP_OKAY;
         awAddr <= '0;
         wData <= 32'h0;
         wStrb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awAddr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wData <= wdata;
            wStrb <= wstrb;
            wready <= 1'b0;
         end
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? teach_pkg::RESP_OKAY : teach_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read side: one cycle from address to data
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= teach_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rdMux;
         rresp <= rdMapped ? teach_pkg::RESP_OKAY : teach_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // configuration registers written by software
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl <= teach_pkg::CTRL_RESET;
         irqMask <= teach_pkg::MASK_RESET;
      end else if (wrFire) begin
         if (isCtrl) ctrl <= ctrlMerged;
         if (isIrqMask) irqMask <= maskMerged;
      end
   end

   // ---------------------------------------------------------------
   // teach sequencer
   // ---------------------------------------------------------------
   wire [15:0] lowPt = (firstPt < curDist) ? firstPt : curDist;
   wire [15:0] highPt = (firstPt < curDist) ? curDist : firstPt;
   wire spanOk = (highPt - lowPt) >= teach_pkg::MIN_SPAN_MM;
   wire pointsOk = lowPt >= teach_pkg::OP_MIN_MM && highPt <= teach_pkg::OP_MAX_MM;
   wire teachGood = spanOk && pointsOk;
   wire completeNow = tState == teach_pkg::T_WAIT && evt.briefPress;
   wire curInOp = curDist >= teach_pkg::OP_MIN_MM && curDist <= teach_pkg::OP_MAX_MM;
   wire idleNow = tState == teach_pkg::T_IDLE;

   always_ff @(posedge clock) begin
      if (distValid || sys_rst) curDist <= sys_rst ? 16'h0 : distance;
   end

   // a long hold that overruns is dropped without touching stored points
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tState <= teach_pkg::T_IDLE;
         firstPt <= teach_pkg::POINT_RESET;
      end else begin
         case (tState)
            teach_pkg::T_IDLE: begin
               if (evt.analogArm) begin
                  firstPt <= curDist;
                  tState <= teach_pkg::T_HOLD;
               end
            end
            teach_pkg::T_HOLD: begin
               if (evt.longAbort) tState <= teach_pkg::T_IDLE;
               else if (evt.analogRelease) tState <= teach_pkg::T_WAIT;
            end
            teach_pkg::T_WAIT: begin
               if (evt.briefPress) tState <= teach_pkg::T_IDLE;
            end
            default: tState <= teach_pkg::T_IDLE;
         endcase
      end
   end

   // stored range is replaced only on a good completion
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         nearPt <= teach_pkg::POINT_RESET;
         farPt <= teach_pkg::POINT_RESET;
         falling <= 1'b0;
         teachErr <= 1'b0;
      end else if (completeNow) begin
         teachErr <= !teachGood;
         if (teachGood) begin
            nearPt <= lowPt;
            farPt <= highPt;
            falling <= firstPt > curDist;
         end
      end
   end

   // switching point and polarity, only outside analog teach
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         switchPoint <= teach_pkg::OP_MAX_MM;
         switchInvert <= 1'b0;
      end else if (idleNow) begin
         if (evt.onePoint && curInOp) switchPoint <= curDist;
         if (evt.invertHold) switchInvert <= !switchInvert;
      end
   end

   // ---------------------------------------------------------------
   // outputs from the measured distance
   // ---------------------------------------------------------------
   wire tooNear = curDist < nearPt;
   wire tooFar = curDist > farPt;
   wire [15:0] inRangeLevel = falling ? farPt - curDist : curDist - nearPt;
   wire [15:0] next_analog = tooNear ? teach_pkg::LEVEL_NEAR : tooFar ? teach_pkg::LEVEL_FAR : inRangeLevel;
   wire [1:0] next_anState = tooNear ? teach_pkg::AN_NEAR : tooFar ? teach_pkg::AN_FAR : teach_pkg::AN_IN;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         analogOutput <= teach_pkg::LEVEL_NEAR;
         anState <= teach_pkg::AN_NEAR;
         switchingOutput <= 1'b0;
      end else begin
         analogOutput <= next_analog;
         anState <= next_anState;
         switchingOutput <= (curDist <= switchPoint) ^ switchInvert;
      end
   end

   // ---------------------------------------------------------------
   // operating modes and shared line
   // ---------------------------------------------------------------
   logic [2:0] trigSync;
   logic [2:0] lineSync;
   logic [7:0] slotMs;
   logic [3:0] slotIdx;
   wire teach_pkg::mode_t mode = teach_pkg::mode_t'(ctrl[teach_pkg::CTRL_MODE_LSB +: 3]);
   wire isMaster = ctrl[teach_pkg::CTRL_MASTER_BIT];
   wire [3:0] nodeIdx = ctrl[teach_pkg::CTRL_NODE_LSB +: 4];
   wire sharedMode = mode == teach_pkg::MODE_MULTIPLEX || mode == teach_pkg::MODE_SYNC
      || mode == teach_pkg::MODE_THROUGHBEAM;
   wire lineRise = lineSync[1] && !lineSync[2];
   wire alignNow = lineRise && sharedMode && !isMaster;
   wire slotStart = evt.msTick && slotMs == 8'h0;
   wire frameStart = slotStart && slotIdx == 4'h0;
   wire slotLast = slotMs == teach_pkg::SLOT_MS - 8'h1;
   wire idxLast = slotIdx == 4'(teach_pkg::MAX_NODES - 1);
   logic next_fire;

   // trigger and line are pins: two flops before use
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         trigSync <= 3'h0;
         lineSync <= 3'h0;
      end else begin
         trigSync <= {trigSync[1:0], trigger};
         lineSync <= {lineSync[1:0], syncLineIn};
      end
   end

   // followers realign their frame to the master pulse
   always_ff @(posedge clock) begin
      if (sys_rst || alignNow) begin
         slotMs <= 8'h0;
         slotIdx <= 4'h0;
      end else if (evt.msTick) begin
         slotMs <= slotLast ? 8'h0 : slotMs + 8'h1;
         if (slotLast) slotIdx <= idxLast ? 4'h0 : slotIdx + 4'h1;
      end
   end

   // firing moment per operating mode
   always_comb begin
      case (mode)
         teach_pkg::MODE_MULTIPLEX: next_fire = slotStart && slotIdx == nodeIdx;
         teach_pkg::MODE_SYNC: next_fire = frameStart;
         teach_pkg::MODE_ACTIVATION: next_fire = trigSync[1] && !trigSync[2];
         teach_pkg::MODE_THROUGHBEAM: next_fire = frameStart;
         default: next_fire = frameStart;
      endcase
   end

   // in shared modes the master drives a one-millisecond pulse at each frame start
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         measureStart <= 1'b0;
         syncLineOut <= 1'b0;
         syncLineOe <= 1'b0;
      end else begin
         measureStart <= next_fire;
         if (frameStart && sharedMode && isMaster) begin
            syncLineOut <= 1'b1;
            syncLineOe <= 1'b1;
         end else if (evt.msTick) begin
            syncLineOut <= 1'b0;
            syncLineOe <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // indicators
   // ---------------------------------------------------------------
   logic [9:0] flashMs;
   logic phase;
   wire inTeach = !idleNow;
   wire [9:0] halfMs = inTeach ? teach_pkg::TEACH_HALF_MS : teach_pkg::ERR_HALF_MS;
   wire halfDone = evt.msTick && flashMs >= halfMs - 10'h1;
   wire next_yellow = inTeach ? phase : teachErr ? phase : switchingOutput;
   wire next_green = inTeach ? !phase : teachErr ? phase : 1'b1;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         flashMs <= 10'h0;
         phase <= 1'b0;
         ledYellow <= 1'b0;
         ledGreen <= 1'b0;
      end else begin
         if (halfDone) begin
            flashMs <= 10'h0;
            phase <= !phase;
         end else if (evt.msTick) begin
            flashMs <= flashMs + 10'h1;
         end
         ledYellow <= next_yellow;
         ledGreen <= next_green;
      end
   end

   // ---------------------------------------------------------------
   // interrupts: set wins over a same-cycle clear
   // ---------------------------------------------------------------
   wire [3:0] irqEvent;
   assign irqEvent[teach_pkg::IRQ_DONE] = completeNow && teachGood;
   assign irqEvent[teach_pkg::IRQ_FAIL] = completeNow && !teachGood;
   assign irqEvent[teach_pkg::IRQ_RANGE] = (tooNear || tooFar) && next_anState != anState;
   assign irqEvent[teach_pkg::IRQ_SWITCH] = idleNow && (evt.onePoint || evt.invertHold);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irqStat <= 4'h0;
         irq <= 1'b0;
      end else begin
         irqStat <= (irqStat & ~irqClear) | irqEvent;
         irq <= |(irqStat & irqMask);
      end
   end
endmodule

// >>> sim/teach_operator.sv
`timescale 1ns/1ps
// ------
// operator on the teach line
// ------
module teach_operator (input wire logic clock, go, input wire logic [31:0] holdCyc,
   input wire logic [15:0] target, output logic teachGnd, distValid, output logic [15:0] distance);
   logic [31:0] left = 0;
   logic [2:0] ph = 0;
   // ground held holdCyc cycles: long arms, short completes
   always @(posedge clock) left <= go ? holdCyc : left - 32'(left != 0);
   always @(posedge clock) ph <= ph + 3'h1;
   assign teachGnd = left != 0;
   assign distValid = ph == 3'h0;
   // inverse off the strobe, so a stray sample shows
   assign distance = distValid ? target : ~target;
endmodule

// >>> sim/analog_teach_sequencer_assertions.sv
`timescale 1ns/1ps
// ------
// port checks
// ------
module analog_teach_sequencer_checker (input wire logic clock, sys_rst, awvalid, awready, wvalid, wready,
   input wire logic bvalid, arvalid, arready, rvalid, measureStart, irq, input wire logic [15:0] analogOutput);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
   sequence s_b_later; !bvalid ##1 bvalid; endsequence
   a_wr_answer: assert property (s_wr_take |=> s_b_later) else $error("write answer");
   a_wr_refuse: assert property ($rose(bvalid) |-> !awready && !wready) else $error("write open");
   a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer");
   a_rd_cause: assert property ($rose(rvalid) |-> $past(arvalid)) else $error("read cause");
   a_rd_refuse: assert property (rvalid |-> !arready) else $error("read open");
   a_start_pulse: assert property (measureStart |=> !measureStart) else $error("start long");
   a_reset_level: assert property (disable iff (1'b0) sys_rst |=>
      analogOutput == teach_pkg::LEVEL_NEAR) else $error("reset level");
   a_reset_irq: assert property (disable iff (1'b0) sys_rst |=> !irq) else $error("reset irq");
endmodule
bind analog_teach_sequencer analog_teach_sequencer_checker i_checker (.*);

// >>> sim/test_analog_teach_sequencer.sv
`timescale 1ns/1ps
module test_analog_teach_sequencer;
   // ------
   // bench
   // ------
   logic clock = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
   logic teachSupply = 0, trigger = 0, awready, wready, bvalid, arready, rvalid, measureStart, ledYellow;
   logic switchingOutput, ledGreen, irq, syncLineOut, syncLineOe, syncLineIn, teachGnd, distValid;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, holdCyc = 0, q[$];
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic [15:0] distance, analogOutput, target = 0, v;
   int failures = 0, n_compared = 0, n, nStart, nLine;
   integer seed = 32'h5daf9a37;
   // undriven line reads low
   assign syncLineIn = syncLineOut & syncLineOe;
   always #2.5 clock = ~clock;
   analog_teach_sequencer #(.TICK_CYCLES(2)) i_analog_teach_sequencer (.*);
   teach_operator i_teach_operator (.*);
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task finish_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // oldest noted read against each read answer
   always @(posedge clock) begin
      if (rvalid && rready) begin
         chk("rdata", q.pop_front(), rdata);
         chk("rresp", 32'(teach_pkg::RESP_OKAY), 32'(rresp));
      end
   end
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      for (n = 0; n < 99 && !bvalid; n++) begin
         @(posedge clock);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end
      bready <= 0;
      chk("bresp", 32'(r), 32'(bresp));
      chk("wait", 0, n / 99);
      @(posedge clock); // bready falls before a following write raises it
      if (n > 98) finish_test;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      {araddr, arvalid, rready} <= {a, 2'h3};
      for (n = 0; n < 99 && !rvalid; n++) begin
         @(posedge clock);
         if (arready) arvalid <= 0;
      end
      rready <= 0;
      chk("wait", 0, n / 99);
      if (n > 98) finish_test;
   endtask
   // hold c cycles, then let the capture land
   task press(input logic [31:0] c);
      {holdCyc, go} <= {c, 1'b1};
      @(posedge clock);
      go <= 0;
      repeat (c + 60) @(posedge clock);
   endtask
   task teach(input logic [15:0] a, input logic [15:0] b);
      target <= a;
      press(16000); // 8 s hold
      chk("alternate", 1, 32'(ledYellow ^ ledGreen));
      target <= b;
      press(1000);
   endtask
   task level(input logic [15:0] d, input logic [15:0] e);
      target <= d;
      repeat (40) @(posedge clock);
      chk("analog", 32'(e), 32'(analogOutput));
   endtask
   // count start pulses and driven line cycles over c edges
   task count(input int c);
      nStart = 0;
      nLine = 0;
      repeat (c) begin
         @(posedge clock);
         nStart += measureStart;
         nLine += syncLineOe;
      end
   endtask
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 0;
      rd(8'h0c, 32'd6000);
      wr(8'h1c, 0, teach_pkg::RESP_SLVERR);
      wr(8'h18, 1, teach_pkg::RESP_OKAY);
      teach(16'd1000, 16'd2000);
      rd(8'h08, 32'h07d0_03e8);
      chk("irq", 1, 32'(irq));
      chk("green", 1, 32'(ledGreen));
      wr(8'h14, 1, teach_pkg::RESP_OKAY);
      repeat (3) @(posedge clock);
      chk("irq", 0, 32'(irq));
      v = 16'd1000 + 16'($random(seed) & 511);
      level(v, v - 16'd1000);
      $display("test rising done");
      teach(16'd3000, 16'd2200);
      rd(8'h08, 32'h0bb8_0898);
      level(16'd2500, 16'd500);
      level(16'd4000, teach_pkg::LEVEL_FAR);
      level(16'd1000, teach_pkg::LEVEL_NEAR);
      $display("test falling done");
      teach(16'd3000, 16'd3300);
      rd(8'h08, 32'h0bb8_0898);
      chk("same", 0, 32'(ledYellow ^ ledGreen));
      $display("test faulty done");
      chk("switch", 1, 32'(switchingOutput));
      teachSupply <= 1;
      repeat (6000) @(posedge clock); // 3 s supply hold
      teachSupply <= 0;
      repeat (60) @(posedge clock);
      chk("invert", 0, 32'(switchingOutput));
      target <= 16'd2500;
      press(6000); // 3 s ground hold
      rd(8'h0c, 32'd2500);
      $display("test switching done");
      wr(8'h00, 32'h0000_0003, teach_pkg::RESP_OKAY);
      trigger <= 1;
      count(600);
      chk("trigger", 1, nStart);
      wr(8'h00, 32'h0000_000a, teach_pkg::RESP_OKAY);
      count(500); // one frame of ten 25 ms slots
      chk("sync start", 1, nStart);
      chk("line", 2, nLine); // 1 ms at two cycles per ms
      $display("test modes done");
      finish_test;
   end
endmodule
